// ---- verilog/adc_pm_params.svh ----
// Constants for the converter power-mode sequencer
`ifndef ADC_PM_PARAMS_SVH
`define ADC_PM_PARAMS_SVH

`define CLK_PERIOD_NS     10
`define WAKE_SHUTDOWN_NS  5000
`define WAKE_STANDBY_NS   1000
`define WAKE_SHUTDOWN_CYC ((`WAKE_SHUTDOWN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_STANDBY_CYC  ((`WAKE_STANDBY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_CNT_W        9
`define CTRL_W            8
`define CTRL_RESET        8'h00
`define CTRL_LAST_RISE    4'h7
`define FRAME_LAST_RISE   4'hf
`define SAMPLE_RISE       4'h1
`define LEAD_ZERO_RISES   4'h4
`define RESULT_W          12
`define PM_LOW_POS        0
`define PM_HIGH_POS       1
`define REF_DIS_POS       5

`endif

// ---- verilog/adc_pm_pkg.sv ----
// Types for the converter power-mode sequencer
package adc_pm_pkg;

  typedef enum logic [1:0] {
    PM_CS_CTRL       = 2'b00,
    PM_ALWAYS_ON     = 2'b01,
    PM_AUTO_SHUTDOWN = 2'b10,
    PM_AUTO_STANDBY  = 2'b11
  } power_mode_t;

  typedef enum logic [1:0] {
    PWR_OFF     = 2'b00,
    PWR_STANDBY = 2'b01,
    PWR_WAKING  = 2'b10,
    PWR_ON      = 2'b11
  } power_state_t;

endpackage

// ---- verilog/edge_sync.sv ----
// Two-flop synchroniser with edge detection for pin inputs
`timescale 1ns/1ps
module edge_sync #(
  parameter int               WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      meta  <= RESET_VAL;
      level <= RESET_VAL;
    end else begin
      meta  <= async_in;
      level <= meta;
    end
  end

  // Delayed copy for edge finding
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      prev <= RESET_VAL;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

// ---- verilog/wake_timer.sv ----
// Power-up delay timer with long and short wake times
`timescale 1ns/1ps
`include "adc_pm_params.svh"
module wake_timer #(
  parameter logic [`WAKE_CNT_W-1:0] LONG_CYC  = `WAKE_CNT_W'(`WAKE_SHUTDOWN_CYC),
  parameter logic [`WAKE_CNT_W-1:0] SHORT_CYC = `WAKE_CNT_W'(`WAKE_STANDBY_CYC)
) (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic start,
  input  wire logic use_long,
  input  wire logic cancel,
  output logic      busy,
  output logic      done
);

  logic [`WAKE_CNT_W-1:0] count;

  // Load on start, count down to one, then finish
  always_ff @(posedge clk_sys) begin
    if (srst || cancel) begin
      count <= '0;
    end else if (start) begin
      count <= use_long ? LONG_CYC : SHORT_CYC;
    end else if (count != '0) begin
      count <= count - `WAKE_CNT_W'(1);
    end
  end

  assign busy = (count != '0);
  assign done = (count == `WAKE_CNT_W'(1)) && !start && !cancel;

endmodule

// ---- verilog/adc_power_mode_control.sv ----
// Power-mode sequencer of a two-channel serial successive-approximation converter
`timescale 1ns/1ps
`include "adc_pm_params.svh"
module adc_power_mode_control (
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  input  wire logic                     cs_n,
  input  wire logic                     sclk,
  input  wire logic                     din,
  input  wire logic [`RESULT_W-1:0]     sar_result,
  output logic                          dout,
  output logic                          dout_en_n,
  output logic [`CTRL_W-1:0]            control_word,
  output adc_pm_pkg::power_mode_t       power_mode,
  output logic                          ref_disable,
  output adc_pm_pkg::power_state_t      power_state,
  output logic                          core_ready,
  output logic                          sample_strobe,
  output logic                          conv_active,
  output logic                          xfer_done
);
  import adc_pm_pkg::*;

  logic [2:0]             pin_level;
  logic [2:0]             pin_rise;
  logic [2:0]             pin_fall;
  logic                   cs_fall;
  logic                   cs_rise;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   din_s;
  logic                   in_xfer;
  logic [3:0]             rise_count;
  logic [`CTRL_W-2:0]     shift_in;
  logic                   fall_pending;
  logic                   wake_on_fall;
  logic                   last_rise;
  logic [15:0]            out_word;
  logic                   wake_start;
  logic                   wake_long;
  logic                   wake_cancel;
  logic                   wake_busy;
  logic                   wake_done;
  power_state_t           next_state;
  logic [`WAKE_CNT_W-1:0] wake_need;
  logic [`WAKE_CNT_W-1:0] wake_age;

  // True for both automatic power-down modes
  function automatic logic is_auto(input power_mode_t m);
    return (m == PM_AUTO_SHUTDOWN) || (m == PM_AUTO_STANDBY);
  endfunction

  // True while the analog core is powered down
  function automatic logic is_asleep(input power_state_t s);
    return (s == PWR_OFF) || (s == PWR_STANDBY);
  endfunction

  // Pin synchronisers: select idles high
  edge_sync #(
    .WIDTH     (3),
    .RESET_VAL (3'h4)
  ) u_pins (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in ({cs_n, sclk, din}),
    .level    (pin_level),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  assign cs_fall   = pin_fall[2];
  assign cs_rise   = pin_rise[2];
  assign sclk_rise = pin_rise[1] && in_xfer;
  assign sclk_fall = pin_fall[1] && in_xfer;
  assign din_s     = pin_level[0];
  assign last_rise = sclk_rise && (rise_count == `FRAME_LAST_RISE);

  // Control fields decoded from the control register; ready flag decoded from the power state
  assign power_mode  = power_mode_t'({control_word[`PM_HIGH_POS],
                                      control_word[`PM_LOW_POS]});
  assign ref_disable = control_word[`REF_DIS_POS];
  assign core_ready  = (power_state == PWR_ON);

  // Transfer window follows the select line
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      in_xfer <= 1'b0;
    end else if (cs_fall) begin
      in_xfer <= 1'b1;
    end else if (cs_rise) begin
      in_xfer <= 1'b0;
    end
  end

  // Rising clock counter; wraps so a held select starts a new frame
  always_ff @(posedge clk_sys) begin
    if (srst || cs_fall) begin
      rise_count <= 4'h0;
    end else if (sclk_rise) begin
      rise_count <= rise_count + 4'h1;
    end
  end

  // First eight rises shift the serial input into the control register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      shift_in     <= '0;
      control_word <= `CTRL_RESET;
    end else if (sclk_rise && rise_count <= `CTRL_LAST_RISE) begin
      shift_in <= {shift_in[`CTRL_W-3:0], din_s};
      if (rise_count == `CTRL_LAST_RISE) begin
        control_word <= {shift_in, din_s};
      end
    end
  end

  // Sample on the second rise, regardless of mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sample_strobe <= 1'b0;
      out_word      <= 16'h0000;
    end else begin
      sample_strobe <= sclk_rise && (rise_count == `SAMPLE_RISE);
      if (cs_fall) begin
        out_word <= 16'h0000;
      end else if (sclk_rise && rise_count == `SAMPLE_RISE) begin
        out_word <= {4'h0, sar_result};
      end
    end
  end

  // Conversion runs from the sample to the last rise
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      conv_active <= 1'b0;
      xfer_done   <= 1'b0;
    end else begin
      xfer_done <= last_rise;
      if (cs_rise || last_rise) begin
        conv_active <= 1'b0;
      end else if (sclk_rise && rise_count == `SAMPLE_RISE) begin
        conv_active <= 1'b1;
      end
    end
  end

  // Serial output: new bit on each falling clock, MSB first
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dout      <= 1'b0;
      dout_en_n <= 1'b1;
    end else begin
      dout_en_n <= !(in_xfer || cs_fall) || cs_rise;
      if (cs_fall) begin
        dout <= 1'b0;
      end else if (sclk_fall) begin
        dout <= out_word[4'hf - rise_count];
      end
    end
  end

  // Marks the first falling clock after select falls
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fall_pending <= 1'b0;
    end else if (cs_fall) begin
      fall_pending <= 1'b1;
    end else if (sclk_fall || cs_rise) begin
      fall_pending <= 1'b0;
    end
  end

  assign wake_on_fall = sclk_fall && fall_pending;

  // Power-state decisions per mode
  always_comb begin
    next_state  = power_state;
    wake_start  = 1'b0;
    wake_long   = 1'b0;
    wake_cancel = 1'b0;
    unique case (power_mode)
      PM_CS_CTRL: begin
        if (cs_rise) begin
          next_state  = PWR_OFF;
          wake_cancel = 1'b1;
        end else if (cs_fall && is_asleep(power_state)) begin
          next_state = PWR_WAKING;
          wake_start = 1'b1;
          wake_long  = !ref_disable && (power_state == PWR_OFF);
        end
      end
      PM_ALWAYS_ON: begin
        if (is_asleep(power_state)) begin
          next_state = PWR_WAKING;
          wake_start = 1'b1;
          wake_long  = !ref_disable && (power_state == PWR_OFF);
        end
      end
      PM_AUTO_SHUTDOWN, PM_AUTO_STANDBY: begin
        if (last_rise) begin
          wake_cancel = 1'b1;
          next_state  = (power_mode == PM_AUTO_STANDBY) ? PWR_STANDBY : PWR_OFF;
        end else if (wake_on_fall && is_asleep(power_state)) begin
          next_state = PWR_WAKING;
          wake_start = 1'b1;
          wake_long  = !ref_disable && (power_state == PWR_OFF);
        end
      end
    endcase
    if (power_state == PWR_WAKING && wake_done && next_state == PWR_WAKING) begin
      next_state = PWR_ON;
    end
  end

  // Power state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      power_state <= PWR_OFF;
    end else begin
      power_state <= next_state;
    end
  end

  // Wake-up delay; host spacing covers it in the slow-wake modes
  wake_timer u_wake (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .start    (wake_start),
    .use_long (wake_long),
    .cancel   (wake_cancel),
    .busy     (wake_busy),
    .done     (wake_done)
  );

  // Helper for checks: requested and elapsed wake cycles
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_need <= '0;
      wake_age  <= '0;
    end else begin
      if (wake_start) begin
        wake_need <= wake_long ? `WAKE_CNT_W'(`WAKE_SHUTDOWN_CYC)
                               : `WAKE_CNT_W'(`WAKE_STANDBY_CYC);
      end
      wake_age <= (power_state == PWR_WAKING) ? wake_age + `WAKE_CNT_W'(1) : '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence s_last_rise(power_mode_t m);
    last_rise && power_mode == m;
  endsequence

  sequence s_auto_wake;
    wake_on_fall && is_auto(power_mode) && is_asleep(power_state);
  endsequence

  a_auto_shutdown: assert property (s_last_rise(PM_AUTO_SHUTDOWN) |=>
    power_state == PWR_OFF && xfer_done)
    else $error("auto shutdown not entered at frame end");

  a_auto_standby: assert property (s_last_rise(PM_AUTO_STANDBY) |=>
    power_state == PWR_STANDBY)
    else $error("standby not entered at frame end");

  a_wake_on_fall: assert property (s_auto_wake |=> power_state == PWR_WAKING ##1
    wake_busy)
    else $error("auto mode did not wake on first falling clock");

  a_cs_shutdown: assert property (power_mode == PM_CS_CTRL && cs_rise |=>
    power_state == PWR_OFF && !conv_active && !wake_busy)
    else $error("select rise did not shut down");

  a_cs_wake: assert property (power_mode == PM_CS_CTRL && cs_fall
    && is_asleep(power_state) |=> power_state == PWR_WAKING)
    else $error("select fall did not start wake");

  a_wake_time: assert property ($rose(core_ready) && $past(power_state) == PWR_WAKING
    |-> wake_age == wake_need)
    else $error("wake-up time wrong");

  a_always_on: assert property (power_mode == PM_ALWAYS_ON && core_ready
    |=> core_ready)
    else $error("always-on mode left full power");

  a_sample_point: assert property (sample_strobe |-> rise_count == 4'h2
    && conv_active)
    else $error("sample not on second rising clock");

  a_frame_length: assert property (xfer_done |-> rise_count == 4'h0
    && $past(rise_count) == `FRAME_LAST_RISE)
    else $error("frame not sixteen clocks");

  a_lead_zeros: assert property (sclk_fall && rise_count < `LEAD_ZERO_RISES |=> !dout)
    else $error("leading zero missing");

  a_zero_load: assert property (sclk_rise && rise_count == `CTRL_LAST_RISE
    && !din_s && shift_in == '0 |=> control_word == 8'h00)
    else $error("low input did not load zeros");

  a_reset_mode: assert property ($past(srst) |-> control_word == `CTRL_RESET
    && power_state == PWR_OFF)
    else $error("reset state wrong");

endmodule

// ---- verification/host_model.sv ----
// Host serial controller model driving select, serial clock and control input
`timescale 1ns/1ps
module host_model (
  output logic      cs_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout
);
  // Idle select high, clock parked high between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // One transfer; gap stretches the wait after the first falling clock
  task automatic frame(input logic [7:0] c, input int gap, input int n,
                       output logic [15:0] rx);
    rx   = '0;
    cs_n = 1'b0;
    #1000;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      din  = (i < 8) ? c[7-i] : 1'b0;
      #62.5;
      if (i == 0) #(gap);
      sclk = 1'b1;
      rx   = {rx[14:0], dout};
      #62.5;
    end
    cs_n = 1'b1;
    din  = ~din; // Released line does not keep its last level
    #100;
  endtask
endmodule

// ---- verification/adc_power_mode_control_tb.sv ----
// Self-checking bench for the converter power-mode sequencer
`timescale 1ns/1ps
`include "adc_pm_params.svh"
module adc_power_mode_control_tb;
  import adc_pm_pkg::*;
  logic                 clk_sys;
  logic                 srst;
  logic                 cs_n;
  logic                 sclk;
  logic                 din;
  logic [`RESULT_W-1:0] sar_result;
  logic                 dout;
  logic                 dout_en_n;
  logic [`CTRL_W-1:0]   control_word;
  power_mode_t          power_mode;
  logic                 ref_disable;
  power_state_t         power_state;
  logic                 core_ready;
  logic                 sample_strobe;
  logic                 conv_active;
  logic                 xfer_done;
  logic [15:0]          rx;
  logic [15:0]          exp_rx;
  int                   n_errors = 0;
  int                   n_compared = 0;
  int                   n_samp = 0;
  int                   n_done = 0;
  int                   wake_run = 0;
  int                   wake_len = 0;

  adc_power_mode_control uut (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .cs_n          (cs_n),
    .sclk          (sclk),
    .din           (din),
    .sar_result    (sar_result),
    .dout          (dout),
    .dout_en_n     (dout_en_n),
    .control_word  (control_word),
    .power_mode    (power_mode),
    .ref_disable   (ref_disable),
    .power_state   (power_state),
    .core_ready    (core_ready),
    .sample_strobe (sample_strobe),
    .conv_active   (conv_active),
    .xfer_done     (xfer_done)
  );

  host_model host (
    .cs_n (cs_n),
    .sclk (sclk),
    .din  (din),
    .dout (dout)
  );

  // 100 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Result changes right after each sample, so a late capture shows
  always @(posedge clk_sys) begin
    if (sample_strobe === 1'b1) begin
      exp_rx <= {4'h0, sar_result};
      sar_result <= #1 sar_result + 12'h3b7;
      n_samp <= n_samp + 1;
    end
    // Frame-end pulses counted so a missing or extra one shows
    if (xfer_done === 1'b1) begin
      n_done <= n_done + 1;
    end
  end

  // Length of the last stretch spent waking
  always @(posedge clk_sys) begin
    if (power_state === PWR_WAKING) begin
      wake_run = wake_run + 1;
    end else begin
      if (wake_run != 0) wake_len = wake_run;
      wake_run = 0;
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One frame, then power state, wake length and returned word
  task automatic run(input logic [7:0] c, input int gap, input int n, input power_state_t e,
                     input power_state_t l, input int wake);
    int s0;
    int d0;
    s0 = n_samp;
    d0 = n_done;
    wake_len = 0;
    @(posedge clk_sys);
    #1;
    fork
      host.frame(c, gap, n, rx);
      begin
        #500;
        check("early_state", power_state, e);
        check("dout_en_early", dout_en_n, 1'b0);
      end
    join
    repeat (10) @(posedge clk_sys);
    check("late_state", power_state, l);
    check("core_ready", core_ready, l == PWR_ON);
    check("dout_en_late", dout_en_n, 1'b1);
    check("wake_cycles", wake_len, wake);
    if (n == 16) begin
      check("result_word", rx, exp_rx);
      check("control_word", control_word, c);
      check("ref_disable", ref_disable, c[5]);
      check("sample_count", n_samp - s0, 1);
      check("done_count", n_done - d0, 1);
    end else begin
      check("conv_active", conv_active, 1'b0);
      check("done_count", n_done - d0, 0);
    end
  endtask

  task automatic t_reset();
    check("control_word", control_word, 8'h00);
    check("power_mode", power_mode, PM_CS_CTRL);
    check("power_state", power_state, PWR_OFF);
    check("dout_en_n", dout_en_n, 1'b1);
  endtask

  task automatic t_cs_mode();
    run(8'h00, 5000, 16, PWR_WAKING, PWR_OFF, 500);
  endtask

  task automatic t_always_on();
    run(8'h01, 5000, 16, PWR_WAKING, PWR_ON, 500);
    run(8'h01, 0, 16, PWR_ON, PWR_ON, 0);
  endtask

  task automatic t_auto_shutdown();
    run(8'h02, 0, 16, PWR_ON, PWR_OFF, 0);
    run(8'h02, 5000, 16, PWR_OFF, PWR_OFF, 500);
  endtask

  task automatic t_standby();
    run(8'h03, 5000, 16, PWR_OFF, PWR_STANDBY, 500);
    run(8'h03, 0, 16, PWR_STANDBY, PWR_STANDBY, 100);
  endtask

  task automatic t_ext_ref();
    run(8'h22, 5000, 16, PWR_STANDBY, PWR_OFF, 100);
    run(8'h22, 5000, 16, PWR_OFF, PWR_OFF, 100);
    run(8'h00, 5000, 16, PWR_OFF, PWR_OFF, 100);
  endtask

  task automatic t_abort();
    run(8'h00, 5000, 5, PWR_WAKING, PWR_OFF, 500);
  endtask

  // Reset, then the scenarios in order
  initial begin
    srst = 1'b1;
    sar_result = 12'ha5c;
    exp_rx = '0;
    repeat (8) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge clk_sys);
    t_reset();
    t_cs_mode();
    t_always_on();
    t_auto_shutdown();
    t_standby();
    t_ext_ref();
    t_abort();
    finish_test();
  end

  // Hang guard, well past the expected run length
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
endmodule
